// [bench/ews_bus_master.sv]
// Behavioural two-wire bus master facing the slave front end
`timescale 1ns/1ps
module ews_bus_master (
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  localparam time QTR = 250;

  // Both lines released at rest so the bus reads idle
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // Start from idle, or repeated Start from a low clock phase
  task automatic start();
    if (!scl) begin
      #QTR sdaLow = 1'b0;
      #QTR scl = 1'b1;
    end
    #(2*QTR) sdaLow = 1'b1;
    #(2*QTR) scl = 1'b0;
  endtask

  // One clock: data moves in the low phase, sampled mid high phase
  task automatic clockBit(input logic b, output logic r);
    #QTR sdaLow = ~b;
    #QTR scl = 1'b1;
    #QTR r = sdaWire;
    #QTR scl = 1'b0;
  endtask

  // Nine gapless clocks: eight bits MSB first, then the answer bit
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      clockBit(tx[i], rx[i]);
    end
  endtask

  // Stop, then leave SCL standing high between frames
  task automatic stop();
    #QTR sdaLow = 1'b1;
    #QTR scl = 1'b1;
    #(2*QTR) sdaLow = 1'b0;
    #(2*QTR);
  endtask

  // Dummy clocks until SDA reads high, nine at the most
  task automatic recover(output int n);
    logic r;
    n = 0;
    do begin
      clockBit(1'b1, r);
      n++;
    end while (r !== 1'b1 && n < 9);
  endtask

  // Spike on SDA shorter than one link clock period
  task automatic glitch();
    sdaLow = 1'b1;
    #20 sdaLow = 1'b0;
  endtask
endmodule

// [bench/ews_slave_bench.sv]
// Self-checking bench for the two-wire slave front end
`timescale 1ns/1ps
module ews_slave_bench;
  localparam logic [3:0] TID    = 4'h5; // Arbitrary type code
  localparam logic [2:0] PINS   = 3'h5;
  localparam logic [7:0] ADDR_W = {TID, PINS, 1'b0};
  localparam logic [7:0] ADDR_R = {TID, PINS, 1'b1};
  localparam int         LIMIT  = 90000;

  logic        clk, resetn, linkClk, scl, sdaLow, sdaWire, sdaOut, sdaOe;
  logic        rxIsAddr, rxValid, txReq, txLoad, writeLaunch, writeDone;
  logic        standby;
  logic [7:0]  rxData, txData, rdNext;
  logic [8:0]  lastRx, rx;
  int          fails, n_tests, cycles, rxCnt, txCnt, wlCnt, n;

  ews_slave #(.TYPE_ID(TID), .SPIKE_CYC(2)) u_ews_slave (
    .clk(clk), .resetn(resetn), .linkClk(linkClk),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .hwAddrPinBit0(PINS[0]), .hwAddrPinBit1(PINS[1]),
    .hwAddrPinBit2(PINS[2]), .rxData(rxData), .rxIsAddr(rxIsAddr),
    .rxValid(rxValid), .txReq(txReq), .txData(txData), .txLoad(txLoad),
    .writeLaunch(writeLaunch), .writeDone(writeDone), .standby(standby)
  );

  ews_bus_master u_ews_bus_master (
    .scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire)
  );

  // Open-drain wire with pull-up: low if either party pulls
  assign sdaWire = ~((sdaOe & ~sdaOut) | sdaLow);

  // System clock and a phase-unrelated link clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  // Collect user-side pulses, answer read requests, cut hangs short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rxValid === 1'b1) begin
      rxCnt  <= rxCnt + 1;
      lastRx <= {rxIsAddr, rxData};
    end
    if (writeLaunch === 1'b1) wlCnt <= wlCnt + 1;
    txLoad <= (txReq === 1'b1);
    if (txReq === 1'b1) begin
      txCnt  <= txCnt + 1;
      txData <= rdNext;
      rdNext <= rdNext + 8'h11;
    end
    if (cycles == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitClk(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Start, address byte, then judge the answer bit
  task automatic addrAck(input logic [7:0] a, input logic ack);
    u_ews_bus_master.start();
    u_ews_bus_master.xfer({a, 1'b1}, rx);
    check(rx[0], !ack);
  endtask

  // Reset state, open-drain output and spike rejection
  task automatic sc_reset();
    check(standby, 1'b1);
    check(sdaOe, 1'b0);
    check(sdaOut, 1'b0);
    u_ews_bus_master.glitch();
    repeat (60) begin
      waitClk(1);
      check(standby, 1'b1);
    end
  endtask

  // Wrong pin bits, then wrong type code
  task automatic sc_mismatch();
    for (int i = 0; i < 2; i++) begin
      addrAck(i ? {4'h3, PINS, 1'b0} : {TID, 3'h4, 1'b0}, 1'b0);
      waitClk(60);
      check(standby, 1'b1);
      check(rxCnt, 0);
      u_ews_bus_master.stop();
    end
  endtask

  // Two data bytes, launch, busy polling, completion
  task automatic sc_write();
    addrAck(ADDR_W, 1'b1);
    check(standby, 1'b0);
    check(lastRx, {1'b1, ADDR_W});
    u_ews_bus_master.xfer({8'h96, 1'b1}, rx);
    check(rx[0], 1'b0);
    check(lastRx, {1'b0, 8'h96});
    u_ews_bus_master.xfer({8'hc3, 1'b1}, rx);
    check(rx[0], 1'b0);
    check(lastRx, {1'b0, 8'hc3});
    u_ews_bus_master.stop();
    check(wlCnt, 1);
    check(standby, 1'b0);
    addrAck(ADDR_W, 1'b0);
    u_ews_bus_master.stop();
    @(posedge clk) writeDone <= 1'b1;
    @(posedge clk) writeDone <= 1'b0;
    waitClk(60);
    check(standby, 1'b1);
    addrAck(ADDR_W, 1'b1);
    u_ews_bus_master.stop();
    check(wlCnt, 1);
  endtask

  // Read two bytes, acknowledge then refuse
  task automatic sc_read();
    @(posedge clk) rdNext <= 8'h3c;
    addrAck(ADDR_R, 1'b1);
    u_ews_bus_master.xfer({8'hff, 1'b0}, rx);
    check(rx[8:1], 8'h3c);
    u_ews_bus_master.xfer({8'hff, 1'b1}, rx);
    check(rx[8:1], 8'h4d);
    waitClk(80);
    check(sdaOe, 1'b0);
    check(standby, 1'b1);
    check(txCnt, 2);
    u_ews_bus_master.stop();
  endtask

  // Write byte then repeated Start into a read
  task automatic sc_restart();
    addrAck(ADDR_W, 1'b1);
    u_ews_bus_master.xfer({8'h5a, 1'b1}, rx);
    addrAck(ADDR_R, 1'b1);
    check(lastRx, {1'b1, ADDR_R});
    u_ews_bus_master.xfer({8'hff, 1'b1}, rx);
    u_ews_bus_master.stop();
    check(wlCnt, 1);
  endtask

  // Start in mid byte restarts at the address byte
  task automatic sc_abort();
    u_ews_bus_master.start();
    repeat (4) u_ews_bus_master.clockBit(1'b1, rx[0]);
    addrAck(ADDR_W, 1'b1);
    check(lastRx, {1'b1, ADDR_W});
    u_ews_bus_master.stop();
  endtask

  // Read abandoned mid byte, recovered by dummy clocks
  task automatic sc_recover();
    @(posedge clk) rdNext <= 8'h00;
    addrAck(ADDR_R, 1'b1);
    repeat (3) u_ews_bus_master.clockBit(1'b1, rx[0]);
    check(rx[0], 1'b0);
    u_ews_bus_master.recover(n);
    check(n <= 9, 1'b1);
    addrAck(ADDR_W, 1'b1);
    u_ews_bus_master.stop();
  endtask

  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Reset long enough for both domains, then the scenarios
  initial begin
    fails = 0;
    n_tests = 0;
    cycles = 0;
    rxCnt = 0;
    txCnt = 0;
    wlCnt = 0;
    lastRx = 9'h000;
    rdNext = 8'h00;
    resetn = 1'b0;
    txData = 8'h00;
    txLoad = 1'b0;
    writeDone = 1'b0;
    repeat (40) @(posedge clk);
    resetn <= 1'b1;
    waitClk(100);
    sc_reset();
    sc_mismatch();
    sc_write();
    sc_read();
    sc_restart();
    sc_abort();
    sc_recover();
    tally_and_finish();
  end
endmodule

// [design/ews_params.svh]
// Constants of the two-wire serial memory slave front end
`ifndef EWS_PARAMS_SVH
`define EWS_PARAMS_SVH
`define EWS_ID_HI 7
`define EWS_ID_LO 4
`define EWS_HW_HI 3
`define EWS_HW_LO 1
`define EWS_RW_BIT 0
`define EWS_LAST_BIT 4'd8
`define EWS_TYPE_ID 4'h5
`define EWS_TX_IDLE 8'hff
`define EWS_PIN_RST 5'h18
`define EWS_SYS_SYNC_RST 4'h1
`define EWS_SPIKE_NS 100
`define EWS_LINK_PS 30000
`define EWS_SPIKE_CYC ((`EWS_SPIKE_NS * 1000 + `EWS_LINK_PS - 1) / `EWS_LINK_PS)
`endif

// [design/ews_pkg.sv]
// Types of the two-wire serial memory slave front end
package ews_pkg;
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_RECV,
    ST_ACK_OUT,
    ST_SEND,
    ST_ACK_IN
  } ews_state_t;

  typedef struct packed {
    ews_state_t  state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        isAddr;
    logic        readMode;
    logic        sdaDrive;
    logic        busy;
    logic        dataWritten;
    logic        sclP;
    logic        sdaP;
    logic        standbyFlag;
    logic [8:0]  rxWord;
    logic        rxTgl;
    logic        reqTgl;
    logic        launchTgl;
    logic [7:0]  txBuf;
    logic        txBufValid;
    logic        ackSeen;
    logic        doneSeen;
  } ews_link_t;

  typedef struct packed {
    logic        rxSeen;
    logic        reqSeen;
    logic        launchSeen;
    logic [7:0]  rxData;
    logic        rxIsAddr;
    logic        rxValid;
    logic        txReq;
    logic        writeLaunch;
    logic        standby;
    logic [7:0]  txHold;
    logic        txAckTgl;
    logic        doneTgl;
  } ews_sys_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } ews_lrst_t;
endpackage

// [design/ews_slave.sv]
// Two-wire serial memory slave front end: bus engine and user side
`timescale 1ns/1ps
`include "ews_params.svh"
module ews_slave #(
  parameter logic [3:0] TYPE_ID   = `EWS_TYPE_ID, // Arbitrary value
  parameter int         SPIKE_CYC = `EWS_SPIKE_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       linkClk,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       hwAddrPinBit0,
  input  wire logic       hwAddrPinBit1,
  input  wire logic       hwAddrPinBit2,
  output logic      [7:0] rxData,
  output logic            rxIsAddr,
  output logic            rxValid,
  output logic            txReq,
  input  wire logic [7:0] txData,
  input  wire logic       txLoad,
  output logic            writeLaunch,
  input  wire logic       writeDone,
  output logic            standby
);
  ews_pkg::ews_link_t lnk_r;
  ews_pkg::ews_link_t lnk_nxt;
  ews_pkg::ews_sys_t  sys_r;
  ews_pkg::ews_sys_t  sys_nxt;
  ews_pkg::ews_lrst_t lrst_r;
  ews_pkg::ews_lrst_t lrst_nxt;

  logic       linkRstn;
  logic       sclF;
  logic       sdaF;
  logic [2:0] hwF;
  logic       ackSync;
  logic       doneSync;
  logic       rxSync;
  logic       reqSync;
  logic       launchSync;
  logic       stbySync;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  logic       driveSlot;
  logic [7:0] txByte;

  // Address byte decode, shared by the engine and its checks
  function automatic logic addrOk(input logic [7:0] b,
                                  input logic [2:0] hw,
                                  input logic       busy,
                                  input logic [3:0] id);
    addrOk = (b[`EWS_ID_HI:`EWS_ID_LO] == id) &&
             (b[`EWS_HW_HI:`EWS_HW_LO] == hw) && !busy;
  endfunction

  // Reset carried into the link domain by two flops
  always_comb begin
    lrst_nxt = '{s1: resetn, s2: lrst_r.s1};
  end

  always_ff @(posedge linkClk) begin
    lrst_r <= lrst_nxt;
  end

  // Reset enters the link side at once and leaves it through two flops,
  // so linkRstn is never left undefined before the first edges
  assign linkRstn = lrst_r.s2 && resetn;

  // Pin sampling with spike rejection
  ews_sync_filter #(
    .WIDTH     (5),
    .STABLE    (SPIKE_CYC),
    .RESET_VAL (`EWS_PIN_RST)
  ) pinFilt (
    .clk    (linkClk),
    .resetn (linkRstn),
    .din    ({sclIn, sdaIn, hwAddrPinBit2, hwAddrPinBit1, hwAddrPinBit0}),
    .dout   ({sclF, sdaF, hwF})
  );

  // Toggles from the user side into the link domain
  ews_sync_filter #(
    .WIDTH     (2),
    .STABLE    (1),
    .RESET_VAL (2'h0)
  ) toLink (
    .clk    (linkClk),
    .resetn (linkRstn),
    .din    ({sys_r.txAckTgl, sys_r.doneTgl}),
    .dout   ({ackSync, doneSync})
  );

  // Toggles and standby level from the link into the user domain
  ews_sync_filter #(
    .WIDTH     (4),
    .STABLE    (1),
    .RESET_VAL (`EWS_SYS_SYNC_RST)
  ) toSys (
    .clk    (clk),
    .resetn (resetn),
    .din    ({lnk_r.rxTgl, lnk_r.reqTgl, lnk_r.launchTgl,
              lnk_r.standbyFlag}),
    .dout   ({rxSync, reqSync, launchSync, stbySync})
  );

  // Bus events seen on the filtered lines
  assign sclRise   = sclF && !lnk_r.sclP;
  assign sclFall   = !sclF && lnk_r.sclP;
  assign startEv   = sclF && lnk_r.sclP && lnk_r.sdaP && !sdaF;
  assign stopEv    = sclF && lnk_r.sclP && !lnk_r.sdaP && sdaF;
  assign driveSlot = sclFall || startEv || stopEv;
  assign txByte    = lnk_r.txBufValid ? lnk_r.txBuf : `EWS_TX_IDLE;

  // Link engine: framing, shifting and acknowledge
  always_comb begin
    lnk_nxt      = lnk_r;
    lnk_nxt.sclP = sclF;
    lnk_nxt.sdaP = sdaF;
    if (doneSync != lnk_r.doneSeen) begin
      lnk_nxt.doneSeen = doneSync;
      lnk_nxt.busy     = 1'b0;
    end
    if (startEv) begin
      lnk_nxt.state       = ews_pkg::ST_RECV;
      lnk_nxt.bitCnt      = 4'd0;
      lnk_nxt.isAddr      = 1'b1;
      lnk_nxt.readMode    = 1'b0;
      lnk_nxt.sdaDrive    = 1'b0;
      lnk_nxt.dataWritten = 1'b0;
    end else if (stopEv) begin
      if (lnk_r.dataWritten && !lnk_r.busy) begin
        lnk_nxt.busy      = 1'b1;
        lnk_nxt.launchTgl = !lnk_r.launchTgl;
      end
      lnk_nxt.state       = ews_pkg::ST_STANDBY;
      lnk_nxt.sdaDrive    = 1'b0;
      lnk_nxt.dataWritten = 1'b0;
    end else begin
      case (lnk_r.state)
        ews_pkg::ST_RECV: begin
          if (sclRise) begin
            lnk_nxt.shift  = {lnk_r.shift[6:0], sdaF};
            lnk_nxt.bitCnt = lnk_r.bitCnt + 4'd1;
          end else if (sclFall && lnk_r.bitCnt == `EWS_LAST_BIT) begin
            lnk_nxt.rxWord = {lnk_r.isAddr, lnk_r.shift};
            if (!lnk_r.isAddr ||
                addrOk(lnk_r.shift, hwF, lnk_r.busy, TYPE_ID)) begin
              lnk_nxt.sdaDrive = 1'b1;
              lnk_nxt.rxTgl    = !lnk_r.rxTgl;
              lnk_nxt.state    = ews_pkg::ST_ACK_OUT;
              if (lnk_r.isAddr) begin
                lnk_nxt.readMode = lnk_r.shift[`EWS_RW_BIT];
                if (lnk_r.shift[`EWS_RW_BIT]) begin
                  lnk_nxt.reqTgl = !lnk_r.reqTgl;
                end
              end else begin
                lnk_nxt.dataWritten = 1'b1;
              end
            end else begin
              lnk_nxt.state = ews_pkg::ST_STANDBY;
            end
          end
        end
        ews_pkg::ST_ACK_OUT: begin
          if (sclFall) begin
            lnk_nxt.sdaDrive = 1'b0;
            lnk_nxt.bitCnt   = 4'd0;
            lnk_nxt.isAddr   = 1'b0;
            if (lnk_r.readMode) begin
              lnk_nxt.state      = ews_pkg::ST_SEND;
              lnk_nxt.shift      = txByte;
              lnk_nxt.sdaDrive   = !txByte[7];
              lnk_nxt.txBufValid = 1'b0;
            end else begin
              lnk_nxt.state = ews_pkg::ST_RECV;
            end
          end
        end
        ews_pkg::ST_SEND: begin
          if (sclRise) begin
            lnk_nxt.bitCnt = lnk_r.bitCnt + 4'd1;
          end else if (sclFall) begin
            if (lnk_r.bitCnt == `EWS_LAST_BIT) begin
              lnk_nxt.sdaDrive = 1'b0;
              lnk_nxt.state    = ews_pkg::ST_ACK_IN;
            end else begin
              lnk_nxt.shift    = {lnk_r.shift[6:0], 1'b0};
              lnk_nxt.sdaDrive = !lnk_r.shift[6];
            end
          end
        end
        ews_pkg::ST_ACK_IN: begin
          if (sclRise && sdaF) begin
            lnk_nxt.state = ews_pkg::ST_STANDBY;
          end else if (sclRise) begin
            // Master acknowledged: ask for the next byte before the fall
            lnk_nxt.reqTgl = !lnk_r.reqTgl;
          end else if (sclFall) begin
            lnk_nxt.state      = ews_pkg::ST_SEND;
            lnk_nxt.bitCnt     = 4'd0;
            lnk_nxt.shift      = txByte;
            lnk_nxt.sdaDrive   = !txByte[7];
            lnk_nxt.txBufValid = 1'b0;
          end
        end
        default: begin
          lnk_nxt.sdaDrive = 1'b0;
        end
      endcase
    end
    if (ackSync != lnk_r.ackSeen) begin
      lnk_nxt.ackSeen    = ackSync;
      lnk_nxt.txBuf      = sys_r.txHold;
      lnk_nxt.txBufValid = 1'b1;
    end
    lnk_nxt.standbyFlag = (lnk_nxt.state == ews_pkg::ST_STANDBY) &&
                          !lnk_nxt.busy;
  end

  // Link state register; reset lands in Standby
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      lnk_r <= '{state: ews_pkg::ST_STANDBY, sclP: 1'b1, sdaP: 1'b1,
                 standbyFlag: 1'b1, default: '0};
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // SDA is open drain: only ever pulled low; SCL is input only
  assign sdaOut = 1'b0;
  assign sdaOe  = lnk_r.sdaDrive;

  // User side: event pulses, received bytes, read data and write done
  always_comb begin
    sys_nxt             = sys_r;
    sys_nxt.rxValid     = 1'b0;
    sys_nxt.txReq       = 1'b0;
    sys_nxt.writeLaunch = 1'b0;
    sys_nxt.standby     = stbySync;
    if (rxSync != sys_r.rxSeen) begin
      sys_nxt.rxSeen   = rxSync;
      sys_nxt.rxData   = lnk_r.rxWord[7:0];
      sys_nxt.rxIsAddr = lnk_r.rxWord[8];
      sys_nxt.rxValid  = 1'b1;
    end
    if (reqSync != sys_r.reqSeen) begin
      sys_nxt.reqSeen = reqSync;
      sys_nxt.txReq   = 1'b1;
    end
    if (launchSync != sys_r.launchSeen) begin
      sys_nxt.launchSeen  = launchSync;
      sys_nxt.writeLaunch = 1'b1;
    end
    if (txLoad) begin
      sys_nxt.txHold   = txData;
      sys_nxt.txAckTgl = !sys_r.txAckTgl;
    end
    if (writeDone) begin
      sys_nxt.doneTgl = !sys_r.doneTgl;
    end
  end

  // User side register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sys_r <= '{standby: 1'b1, default: '0};
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign rxData      = sys_r.rxData;
  assign rxIsAddr    = sys_r.rxIsAddr;
  assign rxValid     = sys_r.rxValid;
  assign txReq       = sys_r.txReq;
  assign writeLaunch = sys_r.writeLaunch;
  assign standby     = sys_r.standby;

  // Checks on the link engine
  a_sda_open_drain:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    sdaOut == 1'b0 && (!sdaOe || lnk_r.state == ews_pkg::ST_ACK_OUT
                       || lnk_r.state == ews_pkg::ST_SEND))
  else $error("SDA pulled low outside acknowledge or read data");

  a_sda_change_low:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    $changed(lnk_r.sdaDrive) |-> $past(driveSlot))
  else $error("SDA drive changed outside an SCL fall or frame edge");

  a_start_restart:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    startEv |=> lnk_r.state == ews_pkg::ST_RECV && lnk_r.bitCnt == 4'd0
               && lnk_r.isAddr && !lnk_r.sdaDrive)
  else $error("Start did not restart address reception");

  a_stop_standby:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    stopEv |=> lnk_r.state == ews_pkg::ST_STANDBY && !sdaOe
               && lnk_r.standbyFlag == !lnk_r.busy)
  else $error("Stop did not return to standby");

  a_stop_launch:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (stopEv && lnk_r.dataWritten && !lnk_r.busy)
      |=> lnk_r.busy && (lnk_r.launchTgl != $past(lnk_r.launchTgl)))
  else $error("Stop after written data did not launch a write");

  a_nack_standby:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_ACK_IN && sclRise && sdaF)
      |=> lnk_r.state == ews_pkg::ST_STANDBY && !sdaOe)
  else $error("Read NACK did not release the bus into standby");

  a_addr_mismatch:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_RECV && sclFall && !startEv && !stopEv
     && lnk_r.isAddr && lnk_r.bitCnt == `EWS_LAST_BIT
     && !addrOk(lnk_r.shift, hwF, lnk_r.busy, TYPE_ID))
      |=> lnk_r.state == ews_pkg::ST_STANDBY && !sdaOe)
  else $error("Mismatching address was acknowledged");

  a_addr_ack:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_RECV && sclFall && !startEv && !stopEv
     && lnk_r.bitCnt == `EWS_LAST_BIT
     && addrOk(lnk_r.shift, hwF, lnk_r.busy, TYPE_ID))
      |=> sdaOe && lnk_r.state == ews_pkg::ST_ACK_OUT)
  else $error("Matching address was not acknowledged");

  a_busy_nack:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_RECV && lnk_r.isAddr && lnk_r.busy
     && lnk_r.bitCnt == `EWS_LAST_BIT && sclFall
     && doneSync == lnk_r.doneSeen) |=> !sdaOe)
  else $error("Address acknowledged during the write cycle");

  a_ack_release:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_ACK_OUT && sclFall && !lnk_r.readMode)
      |=> !sdaOe)
  else $error("Acknowledge not released after the ninth clock");

  a_tx_msb_first:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_SEND && sclFall && !startEv && !stopEv
     && lnk_r.bitCnt != `EWS_LAST_BIT)
      |=> sdaOe == !$past(lnk_r.shift[6]))
  else $error("Read data bit order broken");

  a_eighth_release:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_SEND && sclFall
     && lnk_r.bitCnt == `EWS_LAST_BIT)
      |=> !sdaOe [*2])
  else $error("Transmitter held SDA after the eighth fall");

  a_idle_ignore:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    (lnk_r.state == ews_pkg::ST_STANDBY && !startEv)
      |=> lnk_r.state == ews_pkg::ST_STANDBY && !sdaOe)
  else $error("Standby left without a Start");

  a_bit_count:
  assert property (@(posedge linkClk) disable iff (!linkRstn)
    lnk_r.bitCnt <= `EWS_LAST_BIT)
  else $error("Bit counter ran past eight");
endmodule

// [design/ews_sync_filter.sv]
// Two-flop synchroniser with per-bit stability filter
`timescale 1ns/1ps
module ews_sync_filter #(
  parameter int               WIDTH     = 1,
  parameter int               STABLE    = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  localparam int CW = $clog2(STABLE + 1);

  typedef struct packed {
    logic [WIDTH-1:0]         s1;
    logic [WIDTH-1:0]         s2;
    logic [WIDTH-1:0]         q;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } ews_filt_t;

  ews_filt_t f_r;
  ews_filt_t f_nxt;

  // Output follows a bit only after it held for STABLE samples
  always_comb begin
    f_nxt    = f_r;
    f_nxt.s1 = din;
    f_nxt.s2 = f_r.s1;
    for (int i = 0; i < WIDTH; i++) begin
      if (f_r.s2[i] == f_r.q[i]) begin
        f_nxt.cnt[i] = '0;
      end else if (f_r.cnt[i] == CW'(STABLE - 1)) begin
        f_nxt.q[i]   = f_r.s2[i];
        f_nxt.cnt[i] = '0;
      end else begin
        f_nxt.cnt[i] = f_r.cnt[i] + CW'(1);
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      f_r <= '{s1: RESET_VAL, s2: RESET_VAL, q: RESET_VAL, default: '0};
    end else begin
      f_r <= f_nxt;
    end
  end

  assign dout = f_r.q;
endmodule
